// >>> frrl_regs.svh
// Constants for the fault restart and reference loss supervisor
`ifndef FRRL_REGS_SVH
`define FRRL_REGS_SVH

`define FRRL_CLK_HZ          125000000
`define FRRL_LOSS_WIN_MS     400
`define FRRL_LOSS_WIN_CYC    ((`FRRL_CLK_HZ / 1000) * `FRRL_LOSS_WIN_MS)
`define FRRL_LOSS_DROP_PCT   90
`define FRRL_PCT_FULL        100
`define FRRL_HOLD_PCT        80
`define FRRL_CLEAR_MIN       10
`define FRRL_CLEAR_CYC       (64'd125000000 * 64'd60 * 64'd10)
`define FRRL_LIMIT_MAX       4'ha
`define FRRL_FN_REF_LOST     8'h0c
`define FRRL_FN_RESTART      8'h1e
`define FRRL_FN_W            8
`define FRRL_RIDE_CONT1      2'h1
`define FRRL_RIDE_CONT2      2'h2
`define FRRL_DIAG_CYC        16

`endif

// >>> frrl_pkg.sv
// Types for the fault restart and reference loss supervisor
package frrl_pkg;

    typedef enum logic [1:0] {
        FRRL_RUN,
        FRRL_DIAG,
        FRRL_SEARCH,
        FRRL_TRIP
    } frrl_state_t;

    typedef enum logic [3:0] {
        FRRL_F_EXCESS_CURRENT,
        FRRL_F_GROUND_LEAK,
        FRRL_F_FUSE_OPEN,
        FRRL_F_EXCESS_BUS_V,
        FRRL_F_BUS_UNDERV,
        FRRL_F_SUPPLY_V,
        FRRL_F_MISSING_PHASE,
        FRRL_F_BRAKE_HOT,
        FRRL_F_BRAKE_SWITCH,
        FRRL_F_MOTOR_OVLD,
        FRRL_F_DRIVE_OVLD,
        FRRL_F_MOTOR_HOT,
        FRRL_F_TORQUE_1,
        FRRL_F_TORQUE_2,
        FRRL_F_COUNT
    } frrl_fault_idx_t;

endpackage

// >>> frrl_supervisor.sv
// Fault auto restart, reference loss and brake resistor guard logic
`timescale 1ns/1ns
`default_nettype none
`include "frrl_regs.svh"

module frrl_supervisor #(
    parameter int          REF_W      = 16,
    parameter int          N_OUT      = 5,
    parameter logic [63:0] CLEAR_CYC  = `FRRL_CLEAR_CYC,
    parameter logic [31:0] LOSS_CYC   = `FRRL_LOSS_WIN_CYC
) (
    // Clock, reset, enable
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic                    clk_en,
    // Settings
    input  wire logic                    ref_loss_action_select,
    input  wire logic [3:0]              restart_attempt_limit,
    input  wire logic                    restart_fault_contact_select,
    input  wire logic [N_OUT*8-1:0]      contact_output_function_select,
    input  wire logic [1:0]              power_loss_ride_select,
    input  wire logic                    brake_resistor_guard_enable,
    // Reference and operation
    input  wire logic [REF_W-1:0]        analog_ref,
    input  wire logic                    run_cmd,
    input  wire logic                    fault_reset,
    input  wire logic                    diag_done,
    input  wire logic                    diag_error,
    input  wire logic                    search_done,
    // Fault detectors
    input  wire logic                    excess_current_fault,
    input  wire logic                    ground_leak_fault,
    input  wire logic                    fuse_open_fault,
    input  wire logic                    excess_bus_voltage_fault,
    input  wire logic                    bus_undervoltage_fault,
    input  wire logic                    supply_voltage_fault,
    input  wire logic                    missing_phase_fault,
    input  wire logic                    brake_resistor_hot,
    input  wire logic                    brake_switch_fail,
    input  wire logic                    motor_thermal_overload,
    input  wire logic                    drive_thermal_overload,
    input  wire logic                    motor_hot,
    input  wire logic                    torque_excess_first,
    input  wire logic                    torque_excess_second,
    input  wire logic                    other_fault,
    // Drive and status outputs
    output logic [REF_W-1:0]             speed_ref,
    output logic                         drive_enable,
    output logic                         diag_start,
    output logic                         search_start,
    output logic                         ref_lost,
    output logic                         restart_active,
    output logic                         fault_contact,
    output logic                         trip,
    output logic                         resistor_hot_alarm,
    output logic [3:0]                   attempt_count,
    output logic [N_OUT-1:0]             contact_out
);
    import frrl_pkg::*;

    typedef struct packed {
        frrl_state_t        st;
        logic [31:0]        win_cnt;
        logic [REF_W-1:0]   win_start;
        logic [REF_W-1:0]   held_ref;
        logic               lost;
        logic [63:0]        clean_cnt;
        logic               since_restart;
        logic [3:0]         count;
        logic [REF_W-1:0]   speed;
        logic               drive;
        logic               diag;
        logic               search;
        logic               restart;
        logic               fcontact;
        logic               trip;
        logic               rh_alarm;
        logic [N_OUT-1:0]   contacts;
    } frrl_state_s_t;

    frrl_state_s_t s_q;
    frrl_state_s_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [REF_W-1:0] pct_of(input logic [REF_W-1:0] v,
                                                input logic [7:0] pct);
        logic [REF_W+7:0] prod;
        prod = {8'h00, v} * {{REF_W{1'b0}}, pct};
        return REF_W'(prod / (REF_W+8)'(`FRRL_PCT_FULL));
    endfunction

    logic [FRRL_F_COUNT-1:0] fault_vec;
    logic                    eligible;
    logic                    any_fault;
    logic                    ride_on;
    logic                    rh_active;
    logic [3:0]              limit_eff;

    always_comb
    begin
        rh_active = brake_resistor_hot && brake_resistor_guard_enable;
        ride_on   = (power_loss_ride_select == `FRRL_RIDE_CONT1) ||
                    (power_loss_ride_select == `FRRL_RIDE_CONT2);
        fault_vec = '0;
        fault_vec[FRRL_F_EXCESS_CURRENT] = excess_current_fault;
        fault_vec[FRRL_F_GROUND_LEAK]    = ground_leak_fault;
        fault_vec[FRRL_F_FUSE_OPEN]      = fuse_open_fault;
        fault_vec[FRRL_F_EXCESS_BUS_V]   = excess_bus_voltage_fault;
        fault_vec[FRRL_F_BUS_UNDERV]     = bus_undervoltage_fault && ride_on;
        fault_vec[FRRL_F_SUPPLY_V]       = supply_voltage_fault;
        fault_vec[FRRL_F_MISSING_PHASE]  = missing_phase_fault;
        fault_vec[FRRL_F_BRAKE_HOT]      = rh_active;
        fault_vec[FRRL_F_BRAKE_SWITCH]   = brake_switch_fail;
        fault_vec[FRRL_F_MOTOR_OVLD]     = motor_thermal_overload;
        fault_vec[FRRL_F_DRIVE_OVLD]     = drive_thermal_overload;
        fault_vec[FRRL_F_MOTOR_HOT]      = motor_hot;
        fault_vec[FRRL_F_TORQUE_1]       = torque_excess_first;
        fault_vec[FRRL_F_TORQUE_2]       = torque_excess_second;
        // Undervoltage without ride-through counts as non-eligible
        eligible  = (|fault_vec) && !other_fault &&
                    !(bus_undervoltage_fault && !ride_on);
        any_fault = (|fault_vec) || other_fault || bus_undervoltage_fault;
        limit_eff = (restart_attempt_limit > `FRRL_LIMIT_MAX) ?
                    `FRRL_LIMIT_MAX : restart_attempt_limit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d        = s_q;
        s_d.diag   = 1'b0;
        s_d.search = 1'b0;

        // Reference loss window
        if (s_q.win_cnt >= LOSS_CYC - 32'h1)
        begin
            s_d.win_cnt   = '0;
            s_d.win_start = analog_ref;
            if (!s_q.lost)
                s_d.held_ref = analog_ref;
        end
        else
        begin
            s_d.win_cnt = s_q.win_cnt + 32'h1;
        end
        if (!s_q.lost && s_q.win_start != '0 &&
            analog_ref <= pct_of(s_q.win_start, 8'(`FRRL_PCT_FULL - `FRRL_LOSS_DROP_PCT)))
        begin
            s_d.lost     = 1'b1;
            s_d.held_ref = s_q.win_start;
        end
        else if (s_q.lost && analog_ref > pct_of(s_q.held_ref,
                                                 8'(`FRRL_PCT_FULL - `FRRL_LOSS_DROP_PCT)))
        begin
            s_d.lost = 1'b0;
        end

        if (s_d.lost && ref_loss_action_select)
            s_d.speed = pct_of(s_d.held_ref, 8'(`FRRL_HOLD_PCT));
        else
            s_d.speed = analog_ref;

        // Clean running timer for count clearing
        if (s_q.st == FRRL_RUN && s_q.since_restart && run_cmd && !any_fault)
        begin
            if (s_q.clean_cnt >= CLEAR_CYC - 64'h1)
            begin
                s_d.count         = '0;
                s_d.since_restart = 1'b0;
                s_d.clean_cnt     = '0;
            end
            else
                s_d.clean_cnt = s_q.clean_cnt + 64'h1;
        end
        else
            s_d.clean_cnt = '0;

        unique case (s_q.st)
            FRRL_RUN:
            begin
                s_d.drive = run_cmd;
                if (run_cmd && any_fault)
                begin
                    s_d.drive = 1'b0;
                    if (eligible && s_q.count < limit_eff)
                    begin
                        s_d.st       = FRRL_DIAG;
                        s_d.diag     = 1'b1;
                        s_d.count    = s_q.count + 4'h1;
                        s_d.fcontact = restart_fault_contact_select;
                    end
                    else
                    begin
                        s_d.st       = FRRL_TRIP;
                        s_d.trip     = 1'b1;
                        s_d.fcontact = 1'b1;
                    end
                end
            end
            FRRL_DIAG:
            begin
                if (diag_done && diag_error)
                begin
                    s_d.st       = FRRL_TRIP;
                    s_d.trip     = 1'b1;
                    s_d.fcontact = 1'b1;
                end
                else if (diag_done)
                begin
                    s_d.st     = FRRL_SEARCH;
                    s_d.search = 1'b1;
                end
            end
            FRRL_SEARCH:
            begin
                if (search_done)
                begin
                    s_d.st            = FRRL_RUN;
                    s_d.drive         = run_cmd;
                    s_d.fcontact      = 1'b0;
                    s_d.since_restart = 1'b1;
                end
            end
            FRRL_TRIP:
            begin
                s_d.drive = 1'b0;
                if (fault_reset)
                begin
                    s_d.st            = FRRL_RUN;
                    s_d.count         = '0;
                    s_d.trip          = 1'b0;
                    s_d.fcontact      = 1'b0;
                    s_d.since_restart = 1'b0;
                end
            end
        endcase

        // Resistor overheat coasts the motor
        if (rh_active)
        begin
            s_d.rh_alarm = 1'b1;
            s_d.drive    = 1'b0;
        end
        else if (fault_reset)
            s_d.rh_alarm = 1'b0;

        // Registered restart flag keeps the status output off the state decode
        s_d.restart = (s_d.st == FRRL_DIAG) || (s_d.st == FRRL_SEARCH);

        for (int i = 0; i < N_OUT; i++)
        begin
            s_d.contacts[i] =
                ((contact_output_function_select[i*`FRRL_FN_W +: `FRRL_FN_W] ==
                  `FRRL_FN_REF_LOST) && s_d.lost) ||
                ((contact_output_function_select[i*`FRRL_FN_W +: `FRRL_FN_W] ==
                  `FRRL_FN_RESTART) && s_d.restart);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset models power-up

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s_q    <= '0;
            s_q.st <= FRRL_RUN;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    assign speed_ref          = s_q.speed;
    assign drive_enable       = s_q.drive;
    assign diag_start         = s_q.diag;
    assign search_start       = s_q.search;
    assign ref_lost           = s_q.lost;
    assign restart_active     = s_q.restart;
    assign fault_contact      = s_q.fcontact;
    assign trip               = s_q.trip;
    assign resistor_hot_alarm = s_q.rh_alarm;
    assign attempt_count      = s_q.count;
    assign contact_out        = s_q.contacts;

endmodule // frrl_supervisor

`default_nettype wire

// >>> frrl_sup_sva.sv
// Port assertions for the supervisor
`timescale 1ns/1ns
`default_nettype none
module frrl_sup_sva (
    // Clock and inputs
    input wire logic       ref_clk, rstn, clk_en, run_cmd, fault_reset, other_fault,
    input wire logic       excess_current_fault, bus_undervoltage_fault,
    input wire logic       brake_resistor_hot, brake_resistor_guard_enable,
    input wire logic [1:0] power_loss_ride_select,
    input wire logic [3:0] restart_attempt_limit,
    // Outputs
    input wire logic       diag_start, drive_enable, restart_active, trip, resistor_hot_alarm,
    input wire logic [3:0] attempt_count
);
    logic       idle;
    logic [3:0] lim;
    // Running with no restart or trip in progress
    assign idle = clk_en && run_cmd && !restart_active && !trip;
    assign lim = (restart_attempt_limit > 4'ha) ? 4'ha : restart_attempt_limit;
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    a_diag_entry:
    assert property ($rose(diag_start) |-> restart_active && !drive_enable) else $error("entry");
    a_diag_pulse:
    assert property (clk_en && diag_start |=> !diag_start) else $error("long pulse");
    a_count_step:
    assert property (idle && excess_current_fault && !other_fault && attempt_count < lim
        |=> diag_start && attempt_count == $past(attempt_count) + 4'h1) else $error("step");
    a_limit_trip:
    assert property (idle && excess_current_fault && attempt_count >= lim
        |=> trip && !diag_start) else $error("limit");
    a_other_trip:
    assert property (idle && other_fault |=> trip && !diag_start) else $error("other");
    a_undervolt_trip:
    assert property (idle && bus_undervoltage_fault
        && power_loss_ride_select[0] == power_loss_ride_select[1] |=> trip) else $error("uv");
    a_reset_clear:
    assert property (clk_en && trip && fault_reset |=> attempt_count == 4'h0) else $error("clr");
    a_hot_coast:
    assert property (clk_en && brake_resistor_guard_enable && brake_resistor_hot
        |=> resistor_hot_alarm && !drive_enable) else $error("hot");
endmodule // frrl_sup_sva
////////////////////////////////////////////////////////////////////////////////
bind frrl_supervisor frrl_sup_sva u_sva (.ref_clk, .rstn, .clk_en, .run_cmd, .fault_reset,
    .other_fault, .excess_current_fault, .bus_undervoltage_fault, .brake_resistor_hot,
    .brake_resistor_guard_enable, .power_loss_ride_select, .restart_attempt_limit,
    .diag_start, .drive_enable, .restart_active, .trip, .resistor_hot_alarm, .attempt_count);
`default_nettype wire

// >>> frrl_far_model.sv
// Diagnosis and speed search responder
`timescale 1ns/1ns
`default_nettype none
module frrl_far_model (
    // Clock and bench controls
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [3:0] lag,
    input  wire logic       bad,
    // Handshake with the supervisor
    input  wire logic       diag_start,
    input  wire logic       search_start,
    output logic            diag_done,
    output logic            diag_error,
    output logic            search_done
);
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       srch_q;
    logic       go;
    logic       fin;
    assign go = diag_start || search_start;
    assign fin = busy_q && cnt_q == 4'h0;
    // Answer lag+2 cycles after the start pulse; error line churns while idle
    always_ff @(posedge ref_clk)
    begin
        busy_q      <= rstn && (go || (busy_q && !fin));
        cnt_q       <= go ? lag : cnt_q - 4'h1;
        srch_q      <= go ? search_start : srch_q;
        diag_done   <= fin && !srch_q;
        search_done <= fin && srch_q;
        diag_error  <= fin ? bad : (rstn && !diag_error);
    end
endmodule // frrl_far_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        ref_clk = 1'b0, rstn = 1'b0, run_cmd = 1'b0, fault_reset = 1'b0;
    logic        act = 1'b0, fcsel = 1'b0, guard = 1'b0, bad = 1'b0, en = 1'b1;
    logic [1:0]  ride = 2'h1;
    logic [3:0]  lim = 4'ha, lag = 4'h0;
    logic [14:0] flt = 15'h0;
    logic [15:0] aref = 16'h0;
    logic [39:0] fsel = 40'h1e0c001e0c;
    logic        diag_done, diag_error, search_done, diag_start, search_start, trip;
    logic        drive_enable, ref_lost, restart_active, fault_contact, resistor_hot_alarm;
    logic [3:0]  attempt_count;
    logic [4:0]  contact_out;
    logic [15:0] speed_ref;
    int          bad_count = 0, n_compared = 0, cyc = 0;

    always #4 ref_clk = ~ref_clk;

    frrl_supervisor #(.CLEAR_CYC(64'h32), .LOSS_CYC(32'h14)) DUT (
        .ref_clk, .rstn, .clk_en(en), .ref_loss_action_select(act),
        .restart_attempt_limit(lim), .restart_fault_contact_select(fcsel),
        .contact_output_function_select(fsel), .power_loss_ride_select(ride),
        .brake_resistor_guard_enable(guard), .analog_ref(aref), .run_cmd, .fault_reset,
        .diag_done, .diag_error, .search_done, .excess_current_fault(flt[0]),
        .ground_leak_fault(flt[1]), .fuse_open_fault(flt[2]),
        .excess_bus_voltage_fault(flt[3]), .bus_undervoltage_fault(flt[4]),
        .supply_voltage_fault(flt[5]), .missing_phase_fault(flt[6]),
        .brake_resistor_hot(flt[7]), .brake_switch_fail(flt[8]),
        .motor_thermal_overload(flt[9]), .drive_thermal_overload(flt[10]),
        .motor_hot(flt[11]), .torque_excess_first(flt[12]), .torque_excess_second(flt[13]),
        .other_fault(flt[14]), .speed_ref, .drive_enable, .diag_start, .search_start,
        .ref_lost, .restart_active, .fault_contact, .trip, .resistor_hot_alarm,
        .attempt_count, .contact_out);
    frrl_far_model u_far (.ref_clk, .rstn, .lag, .bad, .diag_start, .search_start,
        .diag_done, .diag_error, .search_done);
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pwr();
        rstn = 1'b0;
        tick(4);
        rstn = 1'b1;
        tick(2);
    endtask
    task automatic hit(input int i);
        flt[i] = 1'b1;
        tick(1);
        flt[i] = 1'b0;
    endtask
    task automatic settle();
        for (int k = 0; k < 99 && restart_active !== 1'b0; k++)
            tick(1);
    endtask
    task automatic clr();
        fault_reset = 1'b1;
        tick(1);
        fault_reset = 1'b0;
        chk(trip, 1'b0);
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            bad_count++;
            $display("[ERR] %0t run too long", $time);
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pwr();
        chk(attempt_count, 4'h0);
        run_cmd = 1'b1;
        guard = 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            fcsel = i[0];
            lag = i[3:0];
            pwr();
            hit(i);
            chk(diag_start, 1'b1);
            chk(attempt_count, 4'h1);
            chk(contact_out, 5'h12);
            chk(fault_contact, i[0]);
            chk(drive_enable, 1'b0);
            settle();
            chk(drive_enable, 1'b1);
            chk(fault_contact, 1'b0);
            chk(resistor_hot_alarm, i == 7);
        end
        $display("restart test done");
        lim = 4'h1;
        lag = 4'h0;
        pwr();
        hit(0);
        tick(3);
        chk(search_start, 1'b1);
        chk(restart_active, 1'b1);
        settle();
        hit(0);
        chk(trip, 1'b1);
        chk(fault_contact, 1'b1);
        clr();
        chk(attempt_count, 4'h0);
        lim = 4'h0;
        hit(0);
        chk(trip, 1'b1);
        clr();
        lim = 4'ha;
        hit(14);
        chk(trip, 1'b1);
        clr();
        ride = 2'h0;
        hit(4);
        chk(trip, 1'b1);
        clr();
        bad = 1'b1;
        hit(1);
        settle();
        chk(trip, 1'b1);
        bad = 1'b0;
        clr();
        $display("trip test done");
        pwr();
        hit(3);
        settle();
        tick(40);
        chk(attempt_count, 4'h1);
        tick(20);
        chk(attempt_count, 4'h0);
        $display("clean run test done");
        act = 1'b1;
        aref = 16'h03e8;
        tick(70);
        chk(speed_ref, 16'h03e8);
        aref = 16'h0065;
        tick(45);
        chk(ref_lost, 1'b0);
        aref = 16'h03e8;
        tick(45);
        aref = 16'h0064;
        tick(45);
        chk(ref_lost, 1'b1);
        chk(contact_out, 5'h09);
        chk(speed_ref, 16'h0320);
        act = 1'b0;
        tick(1);
        chk(speed_ref, 16'h0064);
        $display("reference loss test done");
        guard = 1'b0;
        pwr();
        flt[7] = 1'b1;
        tick(3);
        chk(resistor_hot_alarm, 1'b0);
        chk(drive_enable, 1'b1);
        $display("guard test done");
        en = 1'b0;
        aref = 16'h0200;
        tick(2);
        chk(speed_ref, 16'h0064);
        en = 1'b1;
        tick(1);
        chk(speed_ref, 16'h0200);
        $display("clock enable test done");
        final_report();
    end
endmodule // tb
`default_nettype wire
